// >>> include/tcu_regs.svh
// register offsets, field positions, codes and timing counts of the trace capture unit
// assumes the byte-addressed plain register port of tcu_top, one 32-bit word per register
`ifndef TCU_REGS_SVH
`define TCU_REGS_SVH
// register offsets
`define TCU_OFS_CTRL 8'h00
`define TCU_OFS_CMD 8'h04
`define TCU_OFS_ARG_MOTOR 8'h08
`define TCU_OFS_ARG_VAR 8'h0c
`define TCU_OFS_ARG_VALUE 8'h10
`define TCU_OFS_RESULT 8'h14
`define TCU_OFS_BUF_BASE 8'h18
`define TCU_OFS_BUF_LEN 8'h1c
`define TCU_OFS_BUF_WPTR 8'h20
`define TCU_OFS_STATUS 8'h24
`define TCU_OFS_MASK 8'h28
// control fields: start, stop (trace_stop_condition_cmd), running on read
`define TCU_CTRL_START 0
`define TCU_CTRL_STOP 1
// command word fields
`define TCU_CMD_CODE_MSB 7
`define TCU_CMD_CARD_LSB 8
`define TCU_CMD_CARD_MSB 12
`define TCU_CMD_GET 16
// command codes
`define TCU_CODE_VAR 8'hc8
`define TCU_CODE_PERIOD 8'hc9
`define TCU_CODE_SAMPLES 8'hca
`define TCU_CODE_MODE 8'hcb
// readback word of a trace variable: type, variable id, motor
`define TCU_VW_TYPE_LSB 0
`define TCU_VW_VAR_LSB 8
`define TCU_VW_MOTOR_LSB 16
// status / mask bits
`define TCU_ST_DONE 0
`define TCU_ST_WRAP 1
`define TCU_ST_CFG_ERR 2
`define TCU_ST_CMD_ERR 3
// argument limits
`define TCU_PERIOD_MAX 32'h0000fde8
`define TCU_TYPE_MAX 32'h0000000f
`define TCU_VAR_MAX 32'h00000008
`define TCU_MODE_MAX 32'h00000001
// reset values
`define TCU_RST_PERIOD 16'h0001
`define TCU_RST_LEN 32'h00000000
// timing: chipset cycle and clock period in ns
`define TCU_CHIP_CYCLE_NS 614400
`define TCU_CLK_NS 5
`define TCU_CHIP_CYCLE_CLKS (`TCU_CHIP_CYCLE_NS / `TCU_CLK_NS)
`define TCU_MAX_PER_PERIOD 3'h4
`endif

// >>> include/tcu_pkg.sv
// types of the trace capture unit: engine states, traced quantities, trace modes
// assumes nothing of its surroundings
package tcu_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAIT = 4'h2,
		ST_SEL = 4'h4,
		ST_STORE = 4'h8
	} tcu_state_e;
	typedef enum logic [3:0] {
		VT_NONE = 4'h0, VT_CMD_POS = 4'h1, VT_CMD_VEL = 4'h2, VT_CMD_ACC = 4'h3,
		VT_ACT_POS = 4'h4, VT_ACT_VEL = 4'h5, VT_POS_ERR = 4'h6, VT_PID_ERR = 4'h7,
		VT_EVT_STAT = 4'h8, VT_ACT_STAT = 4'h9, VT_SIG_STAT = 4'ha, VT_INTEGRAL = 4'hb,
		VT_DERIV = 4'hc, VT_MOTOR_CMD = 4'hd, VT_CAPTURE = 4'he, VT_CHIP_TIME = 4'hf
	} tcu_var_type_e;
	typedef enum logic {
		single_pass_capture = 1'b0,
		rolling_capture = 1'b1
	} tcu_mode_e;
endpackage : tcu_pkg

// >>> src/tcu_top.sv
// trace capture unit: samples up to four selected axis quantities each trace period
// assumes a value source answering one cycle after the select, and a buffer write port
// that never stalls; everything on clk
`timescale 1ns/1ps
`include "tcu_regs.svh"

// Notes on behaviour
// - up to four slots stored per period
// - variable command: card, motor, slot, type
// - type code names the traced quantity
// - samples go to consecutive buffer addresses
// - single pass stops when buffer full
// - rolling wraps to buffer start, keeps storing
// - rolling runs until stop, never on full
// - mode command takes only zero or one
// - mode can be read back
// - period counts chipset cycles of 614.4 us
// - trace period measured in chipset cycles
// - buffer setup changes while running refused, flagged
module tcu_top #(
	parameter int CARD_NUM = 1,
	parameter int MOTOR_CHIPS = 2,
	parameter int CYCLE_CLKS = `TCU_CHIP_CYCLE_CLKS
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata_q,
	// traced value source
	output logic [3:0] src_motor_q,
	output tcu_pkg::tcu_var_type_e src_type_q,
	input wire logic [31:0] src_value,
	// trace buffer write port
	output logic mem_we_q,
	output logic [31:0] mem_addr_q,
	output logic [31:0] mem_wdata_q,
	// status
	output logic running_q,
	output logic irq_q
);
	logic rst_meta_q;
	logic rst_n_q;
	tcu_pkg::tcu_state_e state_q;
	logic [7:0] slot_q [8];
	logic [31:0] arg_motor_q, arg_var_q, arg_value_q, result_q;
	logic [31:0] base_q, len_q, wptr_q;
	logic [15:0] period_q, per_cnt_q;
	tcu_pkg::tcu_mode_e mode_q;
	logic [3:0] status_q, mask_q, status_set;
	logic [16:0] tick_cnt_q;
	logic tick_q;
	logic [3:0] idx_q;
	logic [2:0] stored_q;
	logic cmd_wr, cmd_get, motor_ok, var_ok, type_ok, period_ok, mode_ok;
	logic set_var, set_period, set_len, set_mode, cmd_bad, cfg_wr, cfg_refused;
	logic last_loc, start_ok;
	logic [7:0] code;
	logic [2:0] var_idx;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// command decode; a word for another card is ignored without error
	always_comb begin
		code = reg_wdata[`TCU_CMD_CODE_MSB:0];
		cmd_wr = reg_wr && reg_addr == `TCU_OFS_CMD &&
			32'(reg_wdata[`TCU_CMD_CARD_MSB:`TCU_CMD_CARD_LSB]) == CARD_NUM;
		cmd_get = reg_wdata[`TCU_CMD_GET];
		motor_ok = arg_motor_q != 32'h0 && arg_motor_q <= 32'(4 * MOTOR_CHIPS);
		var_ok = arg_var_q != 32'h0 && arg_var_q <= `TCU_VAR_MAX;
		type_ok = arg_value_q <= `TCU_TYPE_MAX;
		period_ok = arg_value_q != 32'h0 && arg_value_q <= `TCU_PERIOD_MAX;
		mode_ok = arg_value_q <= `TCU_MODE_MAX;
		var_idx = 3'(arg_var_q - 32'h1);
		set_var = cmd_wr && !cmd_get && code == `TCU_CODE_VAR && motor_ok && var_ok && type_ok;
		set_period = cmd_wr && !cmd_get && code == `TCU_CODE_PERIOD && period_ok;
		set_mode = cmd_wr && !cmd_get && code == `TCU_CODE_MODE && mode_ok;
		set_len = cmd_wr && !cmd_get && code == `TCU_CODE_SAMPLES && arg_value_q != 32'h0;
		cmd_bad = cmd_wr && !cmd_get && !(set_var || set_period || set_mode || set_len);
		// buffer setup while running is dropped and flagged
		cfg_wr = set_len || (reg_wr && (reg_addr == `TCU_OFS_BUF_BASE ||
			reg_addr == `TCU_OFS_BUF_LEN || reg_addr == `TCU_OFS_BUF_WPTR));
		cfg_refused = cfg_wr && running_q;
		last_loc = wptr_q + 32'h1 >= len_q;
		start_ok = reg_wr && reg_addr == `TCU_OFS_CTRL && reg_wdata[`TCU_CTRL_START] &&
			len_q != 32'h0 && wptr_q < len_q;
	end

	// argument latches, free to change at any time
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			arg_motor_q <= 32'h0;
			arg_var_q <= 32'h0;
			arg_value_q <= 32'h0;
		end else if (reg_wr) begin
			if (reg_addr == `TCU_OFS_ARG_MOTOR) begin
				arg_motor_q <= reg_wdata;
			end else if (reg_addr == `TCU_OFS_ARG_VAR) begin
				arg_var_q <= reg_wdata;
			end else if (reg_addr == `TCU_OFS_ARG_VALUE) begin
				arg_value_q <= reg_wdata;
			end
		end
	end

	// eight selection slots, each motor and type code
	for (genvar g = 0; g < 8; g++) begin : g_slot
		always_ff @(posedge clk or negedge rst_n_q) begin
			if (!rst_n_q) begin
				slot_q[g] <= 8'h00;
			end else if (set_var && var_idx == 3'(g)) begin
				slot_q[g] <= {arg_motor_q[3:0], arg_value_q[3:0]};
			end
		end
	end

	// period and mode settings; readback answers land in the result register
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			period_q <= `TCU_RST_PERIOD;
			mode_q <= tcu_pkg::single_pass_capture;
			result_q <= 32'h0;
		end else begin
			if (set_period) begin
				period_q <= arg_value_q[15:0];
			end
			if (set_mode) begin
				mode_q <= tcu_pkg::tcu_mode_e'(arg_value_q[0]);
			end
			if (cmd_wr && cmd_get) begin
				if (code == `TCU_CODE_VAR) begin
					result_q <= 32'(slot_q[var_idx][3:0]) << `TCU_VW_TYPE_LSB |
						32'(arg_var_q[3:0]) << `TCU_VW_VAR_LSB |
						32'(slot_q[var_idx][7:4]) << `TCU_VW_MOTOR_LSB;
				end else if (code == `TCU_CODE_PERIOD) begin
					result_q <= 32'(period_q);
				end else if (code == `TCU_CODE_SAMPLES) begin
					result_q <= len_q;
				end else if (code == `TCU_CODE_MODE) begin
					result_q <= 32'(mode_q);
				end
			end
		end
	end

	// chipset cycle tick: one per time needed to serve all axes
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tick_cnt_q <= 17'h0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= tick_cnt_q == 17'(CYCLE_CLKS - 1);
			tick_cnt_q <= tick_cnt_q == 17'(CYCLE_CLKS - 1) ? 17'h0 : tick_cnt_q + 17'h1;
		end
	end

	// capture engine; the buffer setup lives here since the engine moves the write position
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= tcu_pkg::ST_IDLE;
			running_q <= 1'b0;
			base_q <= 32'h0;
			len_q <= `TCU_RST_LEN;
			wptr_q <= 32'h0;
			per_cnt_q <= 16'h0;
			idx_q <= 4'h0;
			stored_q <= 3'h0;
			src_motor_q <= 4'h0;
			src_type_q <= tcu_pkg::VT_NONE;
			mem_we_q <= 1'b0;
			mem_addr_q <= 32'h0;
			mem_wdata_q <= 32'h0;
		end else begin
			mem_we_q <= 1'b0;
			if (!running_q && cfg_wr) begin
				if (set_len || reg_addr == `TCU_OFS_BUF_LEN) begin
					len_q <= set_len ? arg_value_q : reg_wdata;
				end else if (reg_addr == `TCU_OFS_BUF_BASE) begin
					base_q <= reg_wdata;
				end else begin
					wptr_q <= reg_wdata;
				end
			end
			if (reg_wr && reg_addr == `TCU_OFS_CTRL && reg_wdata[`TCU_CTRL_STOP]) begin
				// host stop condition ends either mode
				state_q <= tcu_pkg::ST_IDLE;
				running_q <= 1'b0;
			end else begin
				case (state_q)
					tcu_pkg::ST_IDLE: begin
						per_cnt_q <= 16'h0;
						if (start_ok) begin
							running_q <= 1'b1;
							state_q <= tcu_pkg::ST_WAIT;
						end
					end
					tcu_pkg::ST_WAIT: begin
						if (tick_q) begin
							// sample once every period_q chipset cycles
							if (per_cnt_q >= period_q - 16'h1) begin
								per_cnt_q <= 16'h0;
								idx_q <= 4'h0;
								stored_q <= 3'h0;
								state_q <= tcu_pkg::ST_SEL;
							end else begin
								per_cnt_q <= per_cnt_q + 16'h1;
							end
						end
					end
					tcu_pkg::ST_SEL: begin
						if (idx_q == 4'h8 || stored_q == `TCU_MAX_PER_PERIOD) begin
							state_q <= tcu_pkg::ST_WAIT;
						end else if (slot_q[idx_q[2:0]][3:0] == 4'h0) begin
							idx_q <= idx_q + 4'h1;
						end else begin
							src_motor_q <= slot_q[idx_q[2:0]][7:4];
							src_type_q <= tcu_pkg::tcu_var_type_e'(slot_q[idx_q[2:0]][3:0]);
							state_q <= tcu_pkg::ST_STORE;
						end
					end
					tcu_pkg::ST_STORE: begin
						// source answers one cycle after the select
						mem_we_q <= 1'b1;
						mem_addr_q <= base_q + wptr_q;
						mem_wdata_q <= src_value;
						stored_q <= stored_q + 3'h1;
						idx_q <= idx_q + 4'h1;
						if (!last_loc) begin
							wptr_q <= wptr_q + 32'h1;
							state_q <= tcu_pkg::ST_SEL;
						end else if (mode_q == tcu_pkg::rolling_capture) begin
							wptr_q <= 32'h0;
							state_q <= tcu_pkg::ST_SEL;
						end else begin
							// write position parked at the end until the host resets it
							wptr_q <= wptr_q + 32'h1;
							running_q <= 1'b0;
							state_q <= tcu_pkg::ST_IDLE;
						end
					end
					default: begin
						state_q <= tcu_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	// sticky events; a new event in the clearing cycle survives
	always_comb begin
		status_set = 4'h0;
		status_set[`TCU_ST_DONE] = state_q == tcu_pkg::ST_STORE && last_loc &&
			mode_q == tcu_pkg::single_pass_capture;
		status_set[`TCU_ST_WRAP] = state_q == tcu_pkg::ST_STORE && last_loc &&
			mode_q == tcu_pkg::rolling_capture;
		status_set[`TCU_ST_CFG_ERR] = cfg_refused;
		status_set[`TCU_ST_CMD_ERR] = cmd_bad;
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			status_q <= 4'h0;
			mask_q <= 4'h0;
			irq_q <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == `TCU_OFS_STATUS) begin
				status_q <= (status_q & ~reg_wdata[3:0]) | status_set;
			end else begin
				status_q <= status_q | status_set;
			end
			if (reg_wr && reg_addr == `TCU_OFS_MASK) begin
				mask_q <= reg_wdata[3:0];
			end
			irq_q <= |(status_q & mask_q);
		end
	end

	// read data only in the cycle after the strobe; unmapped reads as zero
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			reg_rdata_q <= 32'h0;
		end else if (!reg_rd) begin
			reg_rdata_q <= 32'h0;
		end else if (reg_addr == `TCU_OFS_CTRL) begin
			reg_rdata_q <= {31'h0, running_q};
		end else if (reg_addr == `TCU_OFS_ARG_MOTOR) begin
			reg_rdata_q <= arg_motor_q;
		end else if (reg_addr == `TCU_OFS_ARG_VAR) begin
			reg_rdata_q <= arg_var_q;
		end else if (reg_addr == `TCU_OFS_ARG_VALUE) begin
			reg_rdata_q <= arg_value_q;
		end else if (reg_addr == `TCU_OFS_RESULT) begin
			reg_rdata_q <= result_q;
		end else if (reg_addr == `TCU_OFS_BUF_BASE) begin
			reg_rdata_q <= base_q;
		end else if (reg_addr == `TCU_OFS_BUF_LEN) begin
			reg_rdata_q <= len_q;
		end else if (reg_addr == `TCU_OFS_BUF_WPTR) begin
			reg_rdata_q <= wptr_q;
		end else if (reg_addr == `TCU_OFS_STATUS) begin
			reg_rdata_q <= {28'h0, status_q};
		end else if (reg_addr == `TCU_OFS_MASK) begin
			reg_rdata_q <= {28'h0, mask_q};
		end else begin
			reg_rdata_q <= 32'h0;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n_q);

	chk_max_four: assert property (stored_q <= `TCU_MAX_PER_PERIOD)
		else $error("more than four samples in one period");
	chk_type_decode: assert property (state_q == tcu_pkg::ST_STORE |->
		src_type_q != tcu_pkg::VT_NONE && src_type_q == $past(slot_q[idx_q[2:0]][3:0]))
		else $error("traced type does not match slot");
	chk_var_store: assert property (set_var |=> slot_q[$past(var_idx)] ==
		{$past(arg_motor_q[3:0]), $past(arg_value_q[3:0])})
		else $error("variable command not stored");
	chk_addr_advance: assert property (state_q == tcu_pkg::ST_STORE && !last_loc &&
		!reg_wr |=> mem_we_q && mem_addr_q == $past(base_q + wptr_q) &&
		wptr_q == $past(wptr_q) + 32'h1)
		else $error("write position did not advance");
	chk_single_stop: assert property (state_q == tcu_pkg::ST_STORE && last_loc && !reg_wr &&
		mode_q == tcu_pkg::single_pass_capture |=> !running_q ##1 !mem_we_q)
		else $error("single pass did not stop when full");
	chk_roll_wrap: assert property (state_q == tcu_pkg::ST_STORE && last_loc && !reg_wr &&
		mode_q == tcu_pkg::rolling_capture |=> wptr_q == 32'h0 && running_q)
		else $error("rolling mode did not wrap");
	chk_mode_range: assert property (cmd_wr && !cmd_get && code == `TCU_CODE_MODE &&
		arg_value_q > `TCU_MODE_MAX |=> mode_q == $past(mode_q) && status_q[`TCU_ST_CMD_ERR])
		else $error("illegal mode accepted");
	chk_mode_read: assert property (cmd_wr && cmd_get && code == `TCU_CODE_MODE |=>
		result_q == 32'($past(mode_q)))
		else $error("mode readback wrong");
	chk_period_wait: assert property (state_q == tcu_pkg::ST_WAIT &&
		$past(state_q) == tcu_pkg::ST_IDLE |-> !tick_q || period_q == 16'h1 ##1
		state_q != tcu_pkg::ST_SEL || period_q == 16'h1)
		else $error("sampling ahead of the period");
	chk_cfg_locked: assert property (running_q && reg_wr &&
		reg_addr == `TCU_OFS_BUF_BASE |=> base_q == $past(base_q) && status_q[`TCU_ST_CFG_ERR])
		else $error("buffer setup changed while running");
	chk_zero_skip: assert property (state_q == tcu_pkg::ST_SEL && idx_q < 4'h8 &&
		stored_q < 3'h4 && slot_q[idx_q[2:0]][3:0] == 4'h0 && !reg_wr |=>
		state_q == tcu_pkg::ST_SEL && idx_q == $past(idx_q) + 4'h1)
		else $error("empty slot not skipped");
	chk_ascending: assert property (state_q == tcu_pkg::ST_STORE && !reg_wr |=>
		idx_q == $past(idx_q) + 4'h1)
		else $error("slots not taken in ascending order");
	chk_irq_level: assert property (##1 irq_q == |($past(status_q) & $past(mask_q)))
		else $error("interrupt level wrong");

	cov_store: cover property (mem_we_q);
	cov_single_done: cover property (status_q[`TCU_ST_DONE]);
	cov_roll_wrap: cover property (status_q[`TCU_ST_WRAP] && running_q);
	cov_cfg_refused: cover property (cfg_refused);
endmodule : tcu_top

// >>> test/tcu_src_model.sv
// value source and trace buffer model for the trace capture unit bench
// assumes the unit selects a source one cycle before it samples src_value
`timescale 1ns/1ps
module tcu_src_model (
	// clock
	input wire logic clk,
	// source select and value
	input wire logic [3:0] src_motor_q,
	input wire tcu_pkg::tcu_var_type_e src_type_q,
	output logic [31:0] src_value,
	// buffer write port
	input wire logic mem_we_q,
	input wire logic [31:0] mem_addr_q,
	input wire logic [31:0] mem_wdata_q
);
	logic [31:0] wr_addr [0:63];
	logic [31:0] wr_data [0:63];
	time wr_time [0:63];
	int n_wr = 0;
	logic [31:0] noise_q = 32'h00000000;
	// nothing selected: value moves every cycle so a stale sample shows
	always @(posedge clk) begin
		noise_q <= noise_q + 32'h9e3779b9;
	end
	// distinct word per motor and quantity, answered without delay
	always_comb begin
		if (src_type_q == tcu_pkg::VT_NONE) begin
			src_value = noise_q;
		end else begin
			src_value = {8'ha5, 12'h000, src_motor_q, 4'h0, 4'(src_type_q)};
		end
	end
	// record up to 64 buffer writes; bench clears n_wr between traces
	always @(posedge clk) begin
		if (mem_we_q && n_wr < 64) begin
			wr_addr[n_wr] <= mem_addr_q;
			wr_data[n_wr] <= mem_wdata_q;
			wr_time[n_wr] <= $time;
			n_wr <= n_wr + 1;
		end
	end
endmodule : tcu_src_model

// >>> test/tb_tcu_top.sv
// self-checking bench of the trace capture unit: register port tasks and trace runs
// assumes tcu_top with a short chipset cycle so a trace run takes few clocks
`timescale 1ns/1ps
`include "tcu_regs.svh"
module tb_tcu_top;
	localparam int CYC = 32;
	logic clk, nrst, reg_wr, reg_rd, mem_we_q, running_q, irq_q;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata_q, src_value, mem_addr_q, mem_wdata_q;
	logic [3:0] src_motor_q;
	tcu_pkg::tcu_var_type_e src_type_q;
	int n_mismatch = 0;
	int comparisons = 0;
	int i;
	// first four enabled slots in ascending order: motor and type of each
	logic [3:0] sl_m [0:3] = '{4'h3, 4'h3, 4'h8, 4'h5};
	logic [3:0] sl_t [0:3] = '{4'hf, 4'h4, 4'h1, 4'h2};
	logic [7:0] sl_v [0:3] = '{8'h01, 8'h02, 8'h05, 8'h06};

	tcu_top #(.CYCLE_CLKS(CYC)) dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.src_motor_q(src_motor_q), .src_type_q(src_type_q), .src_value(src_value),
		.mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
		.running_q(running_q), .irq_q(irq_q));
	tcu_src_model u (.clk(clk), .src_motor_q(src_motor_q), .src_type_q(src_type_q),
		.src_value(src_value), .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q),
		.mem_wdata_q(mem_wdata_q));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic logic [31:0] exp_val(input logic [3:0] m, input logic [3:0] t);
		return {8'ha5, 12'h000, m, 4'h0, t};
	endfunction : exp_val

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata_q, exp, what);
	endtask : rdchk

	task automatic cmd(input logic [7:0] code, input logic [31:0] m, input logic [31:0] v,
		input logic [31:0] val, input logic get, input logic [4:0] card);
		wr(`TCU_OFS_ARG_MOTOR, m);
		wr(`TCU_OFS_ARG_VAR, v);
		wr(`TCU_OFS_ARG_VALUE, val);
		wr(`TCU_OFS_CMD, {15'h0000, get, 3'h0, card, code});
	endtask : cmd

	// interrupt pin read only after status and mask have settled, never at the call
	task automatic chk_flag(input logic exp, input string what);
		repeat (2) @(posedge clk);
		#1 chk({31'h0, irq_q}, {31'h0, exp}, what);
	endtask : chk_flag

	// bounded wait for the trace to end
	task automatic wait_idle(input int lim);
		int k;
		k = 0;
		while (running_q !== 1'b0 && k < lim) begin
			@(posedge clk);
			k++;
		end
		// let the model record the last buffer write of this edge
		#1;
		chk({31'h0, running_q}, 32'h0, "trace still running");
	endtask : wait_idle

	task automatic chk_writes(input logic [31:0] base, input int len, input int n);
		for (int k = 0; k < n; k++) begin
			chk(u.wr_addr[k], base + 32'(k % len), "buffer address");
			chk(u.wr_data[k], exp_val(sl_m[k % 4], sl_t[k % 4]), "sample");
		end
	endtask : chk_writes

	// hang guard, far beyond the several hundred cycles the run needs
	initial begin
		#100000;
		n_mismatch++;
		end_sim();
	end

	initial begin
		nrst = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h00000000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		// reset state and an unmapped address
		rdchk(`TCU_OFS_CTRL, 32'h0, "ctrl");
		rdchk(`TCU_OFS_STATUS, 32'h0, "status");
		rdchk(`TCU_OFS_MASK, 32'h0, "mask");
		rdchk(`TCU_OFS_BUF_LEN, 32'h0, "len");
		rdchk(8'h2c, 32'h0, "unmapped");
		cmd(`TCU_CODE_MODE, 0, 0, 0, 1'b1, 5'h01);
		rdchk(`TCU_OFS_RESULT, 32'h0, "mode at reset");
		cmd(`TCU_CODE_PERIOD, 0, 0, 0, 1'b1, 5'h01);
		rdchk(`TCU_OFS_RESULT, 32'h1, "period at reset");
		// mode codes, an illegal one, a foreign card
		cmd(`TCU_CODE_MODE, 0, 0, 1, 1'b0, 5'h01);
		cmd(`TCU_CODE_MODE, 0, 0, 2, 1'b0, 5'h01);
		cmd(`TCU_CODE_MODE, 0, 0, 0, 1'b0, 5'h02);
		cmd(`TCU_CODE_MODE, 0, 0, 0, 1'b1, 5'h01);
		rdchk(`TCU_OFS_RESULT, 32'h1, "mode readback");
		rdchk(`TCU_OFS_STATUS, 32'h8, "bad mode flagged");
		// interrupt: unmask, raise, clear
		wr(`TCU_OFS_MASK, 32'h8);
		chk_flag(1'b1, "irq on bad command");
		wr(`TCU_OFS_STATUS, 32'h8);
		chk_flag(1'b0, "irq after clear");
		// every quantity code through slot 8 and back
		for (i = 0; i < 16; i++) begin
			cmd(`TCU_CODE_VAR, 1, 8, i, 1'b0, 5'h01);
			cmd(`TCU_CODE_VAR, 0, 8, 0, 1'b1, 5'h01);
			rdchk(`TCU_OFS_RESULT, {12'h000, 4'h1, 8'h08, 4'h0, 4'(i)}, "type");
		end
		for (i = 0; i < 4; i++) begin
			cmd(`TCU_CODE_VAR, sl_m[i], sl_v[i], sl_t[i], 1'b0, 5'h01);
		end
		cmd(`TCU_CODE_VAR, 1, 7, 3, 1'b0, 5'h01);
		cmd(`TCU_CODE_VAR, 9, 1, 1, 1'b0, 5'h01);
		cmd(`TCU_CODE_VAR, 1, 9, 1, 1'b0, 5'h01);
		cmd(`TCU_CODE_VAR, 1, 1, 16, 1'b0, 5'h01);
		cmd(`TCU_CODE_VAR, 0, 1, 0, 1'b1, 5'h01);
		rdchk(`TCU_OFS_RESULT, 32'h0003010f, "slot 1 kept");
		rdchk(`TCU_OFS_STATUS, 32'h8, "bad arguments");
		wr(`TCU_OFS_STATUS, 32'hf);
		// single pass of six words, period two chipset cycles
		cmd(`TCU_CODE_PERIOD, 0, 0, 2, 1'b0, 5'h01);
		cmd(`TCU_CODE_MODE, 0, 0, 0, 1'b0, 5'h01);
		wr(`TCU_OFS_BUF_BASE, 32'h100);
		wr(`TCU_OFS_BUF_LEN, 32'h6);
		wr(`TCU_OFS_BUF_WPTR, 32'h0);
		u.n_wr = 0;
		wr(`TCU_OFS_CTRL, 32'h1);
		wr(`TCU_OFS_BUF_LEN, 32'h40);
		wr(`TCU_OFS_BUF_BASE, 32'h300);
		rdchk(`TCU_OFS_STATUS, 32'h4, "change flagged");
		rdchk(`TCU_OFS_BUF_LEN, 32'h6, "len kept");
		rdchk(`TCU_OFS_BUF_BASE, 32'h100, "base kept");
		rdchk(`TCU_OFS_CTRL, 32'h1, "running");
		wait_idle(1000);
		chk(32'(u.n_wr), 32'h6, "write count");
		chk_writes(32'h100, 6, 6);
		chk(32'(u.wr_time[4] - u.wr_time[0]), 32'(2 * CYC * 5), "period");
		rdchk(`TCU_OFS_STATUS, 32'h5, "full flag");
		wr(`TCU_OFS_STATUS, 32'hf);
		// rolling over three words until stopped
		cmd(`TCU_CODE_MODE, 0, 0, 1, 1'b0, 5'h01);
		wr(`TCU_OFS_BUF_BASE, 32'h200);
		wr(`TCU_OFS_BUF_LEN, 32'h3);
		wr(`TCU_OFS_BUF_WPTR, 32'h0);
		u.n_wr = 0;
		wr(`TCU_OFS_CTRL, 32'h1);
		i = 0;
		while (u.n_wr < 7 && i < 1000) begin
			@(posedge clk);
			i++;
		end
		rdchk(`TCU_OFS_CTRL, 32'h1, "still running");
		wr(`TCU_OFS_MASK, 32'h2);
		chk_flag(1'b1, "irq on wrap");
		wr(`TCU_OFS_CTRL, 32'h2);
		wait_idle(4);
		chk({31'h0, u.n_wr >= 7}, 32'h1, "rolling writes");
		chk_writes(32'h200, 3, 7);
		rdchk(`TCU_OFS_STATUS, 32'h2, "wrap flag");
		end_sim();
	end
endmodule : tb_tcu_top
